//--- common/cfg_image_pkg.sv
/*
 * constants and carrier types for the configuration image decoder.
 * assumes a single synchronous clock domain and a host that presents
 * the whole ten-word output image with one strobe per network cycle.
 */
package cfg_image_pkg;

    localparam int unsigned WORD_W      = 16;
    localparam int unsigned IMAGE_WORDS = 10;   // twenty bytes each way
    localparam int unsigned IMAGE_BYTES = 20;

    // word indices of the configuration layout
    localparam int unsigned W_CTRL_A    = 0;
    localparam int unsigned W_CTRL_B    = 1;
    localparam int unsigned W_SPD_UP    = 2;
    localparam int unsigned W_SPD_LO    = 3;
    localparam int unsigned W_STEPS     = 4;
    localparam int unsigned W_RSVD5     = 5;
    localparam int unsigned W_ENC       = 6;
    localparam int unsigned W_IDLE      = 7;
    localparam int unsigned W_CURR      = 8;
    localparam int unsigned W_RSVD9     = 9;

    // bit positions
    localparam int unsigned B_MODE_SEL  = 15;  // word 0: 1 config, 0 command
    localparam int unsigned B_OUT_FMT   = 0;   // word 1: binary output format
    localparam int unsigned B_IN_FMT    = 1;   // word 1: binary input format
    localparam int unsigned B_ENDIAN    = 2;   // word 1: big-endian order
    localparam int unsigned B_DRV_EN    = 0;   // command word 0: driver enable

    // ranges
    localparam int          SPD_MIN     = 1;
    localparam int          SPD_MAX     = 1999999;
    localparam int          STEPS_MIN   = 200;
    localparam int          STEPS_MAX   = 32767;
    localparam int          IDLE_MAX    = 100;
    localparam int          CURR_MIN    = 1;
    localparam int          CURR_MAX    = 20;
    localparam int          ENC_1K      = 1024;
    localparam int          ENC_2K      = 2048;
    localparam int          ENC_4K      = 4096;
    localparam int          MW_SCALE    = 1000;
    localparam int          MW_MIN      = -32768000;
    localparam int          MW_MAX      = 32767999;

    // reset values
    localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;

    typedef logic [IMAGE_WORDS-1:0][WORD_W-1:0] image_t;

    typedef enum logic [1:0] {
        FMT_MULTI  = 2'b00,
        FMT_BIN_LE = 2'b01,
        FMT_BIN_BE = 2'b11
    } wide_fmt_t;

    typedef struct packed {
        logic                use_bin_out;
        logic                use_bin_in;
        logic                big_endian;
        logic [WORD_W-1:0]   ctrl_a;
        logic [WORD_W-1:0]   ctrl_b;
        logic [31:0]         start_speed;
        logic [WORD_W-1:0]   steps_per_rev;
        logic [WORD_W-1:0]   encoder_counts;
        logic [WORD_W-1:0]   idle_pct;
        logic [WORD_W-1:0]   run_current;
    } cfg_t;

    typedef enum logic [1:0] {
        ST_BOOT    = 2'b00,
        ST_COMMAND = 2'b01,
        ST_CONFIG  = 2'b11
    } op_state_t;

endpackage : cfg_image_pkg

//--- verification/cfg_image_properties.sv
/* checker bound to the image decoder ports.
   assumes one clk_sys domain, rst synchronous active high. */
`timescale 1ns/100ps
module cfg_image_checker
    import cfg_image_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire cfg_image_pkg::image_t out_image,
    input wire logic                  image_valid,
    input wire logic                  store_req,
    input wire logic                  abs_encoder,
    input wire logic                  nv_present,
    input wire cfg_image_pkg::cfg_t   nv_cfg,
    input wire logic                  config_mode,
    input wire logic                  driver_enable,
    input wire logic                  cfg_valid,
    input wire logic                  cfg_reject,
    input wire logic                  nv_write,
    input wire cfg_image_pkg::cfg_t   cfg_out,
    input wire logic [31:0]           target_pos
);
    logic        boot_r;
    logic        taken;
    logic        enc_bad;
    logic        bad;
    logic [31:0] bin_word;
    int          pair_mw;

    // images are ignored in the boot cycle just after reset release
    always_ff @(posedge clk_sys) boot_r <= rst;
    assign taken = image_valid && !boot_r;
    assign pair_mw = int'($signed(out_image[W_SPD_UP])) * MW_SCALE
                   + int'($signed(out_image[W_SPD_LO]));
    assign bin_word = cfg_out.big_endian
        ? {out_image[W_SPD_UP], out_image[W_SPD_LO]}
        : {out_image[W_SPD_LO], out_image[W_SPD_UP]};
    assign enc_bad = out_image[W_CTRL_A][10] && (abs_encoder
        ? out_image[W_ENC] != 16'h0800
        : !(out_image[W_ENC] inside {16'h0400, 16'h0800, 16'h1000}));
    assign bad = pair_mw < SPD_MIN || pair_mw > SPD_MAX || enc_bad
        || out_image[W_STEPS] < STEPS_MIN || out_image[W_STEPS] > STEPS_MAX
        || out_image[W_IDLE] > IDLE_MAX || out_image[W_CURR] < CURR_MIN
        || out_image[W_CURR] > CURR_MAX
        || out_image[W_RSVD5] != '0 || out_image[W_RSVD9] != '0;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_cmd;
        taken && !out_image[W_CTRL_A][B_MODE_SEL];
    endsequence
    sequence s_cfg;
        taken && out_image[W_CTRL_A][B_MODE_SEL];
    endsequence

    AST_CMD_MODE: assert property (s_cmd |=> !config_mode)
        else $error("command image left config mode set");
    AST_CMD_CFG: assert property (s_cmd |=> $stable(cfg_out))
        else $error("command image altered configuration");
    AST_CFG_OK: assert property (s_cfg ##0 !bad |=> config_mode
        && cfg_valid && !cfg_reject) else $error("good config not taken");
    AST_REJECT: assert property (s_cfg ##0 bad |=> cfg_reject
        && $stable(cfg_out)) else $error("bad config not refused");
    AST_BOOT: assert property (boot_r |-> !config_mode
        && !driver_enable && !nv_write) else $error("boot outputs not idle");
    AST_BOOT_LOAD: assert property (boot_r && nv_present |=>
        cfg_valid && cfg_out == $past(nv_cfg)) else $error("no nv load");
    AST_DRV: assert property (driver_enable |-> cfg_valid)
        else $error("driver on without configuration");
    AST_STORE: assert property (store_req && cfg_valid |=>
        nv_write ##1 !nv_write) else $error("store pulse wrong");
    AST_NO_STORE: assert property (nv_write |-> $past(store_req)
        && $past(cfg_valid)) else $error("unrequested store");
    AST_TGT_MW: assert property (s_cmd ##0 !cfg_out.use_bin_out
        |=> target_pos == 32'($past(pair_mw))) else $error("two-word tgt");
    AST_TGT_BIN: assert property (s_cmd ##0 cfg_out.use_bin_out
        |=> target_pos == $past(bin_word)) else $error("binary target");
endmodule : cfg_image_checker

bind cfg_image_decoder cfg_image_checker i_chk (.clk_sys, .rst, .out_image,
    .image_valid, .store_req, .abs_encoder, .nv_present, .nv_cfg,
    .config_mode, .driver_enable, .cfg_valid, .cfg_reject, .nv_write,
    .cfg_out, .target_pos);

//--- verification/config_image_word_format_test.sv
/* bench: host model feeding the decoder, checker bound inside.
   assumes positions stay constant; images come only via i_host. */
`timescale 1ns/100ps
module config_image_word_format_test;
    import cfg_image_pkg::*;
    logic        clk_sys, rst, store_req, abs_encoder, nv_present;
    logic        image_valid, config_mode, driver_enable;
    logic        cfg_valid, cfg_reject, nv_write;
    logic [31:0] motor_pos, encoder_pos, capture_pos, target_pos;
    logic [31:0] prog_speed, stop_dist;
    logic [2:0]  fmts[4];
    cfg_t        nv_cfg, cfg_out;
    image_t      out_image, in_image, img;
    int          n_fail, check_count, last_spd;
    int          tbl[11][6];

    plc_host_model i_host (.clk_sys, .out_image, .image_valid);
    cfg_image_decoder i_dut (.clk_sys, .rst, .out_image, .image_valid,
        .store_req, .abs_encoder, .nv_present, .nv_cfg, .motor_pos,
        .encoder_pos, .capture_pos, .config_mode, .driver_enable,
        .cfg_valid, .cfg_reject, .nv_write, .cfg_out, .target_pos,
        .prog_speed, .stop_dist, .in_image);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic results;
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // {first word, second word} of a wide value in the chosen form
    function automatic logic [31:0] pair(int v, logic bin, logic be);
        if (!bin) return {16'(v / MW_SCALE), 16'(v % MW_SCALE)};
        return be ? 32'(v) : {16'(v), 16'(v >>> 16)};
    endfunction : pair

    function automatic image_t cfg_img(int r[6], logic [2:0] fmt);
        image_t i;
        i = '0;
        i[W_CTRL_A] = 16'h8400;
        i[W_CTRL_B] = {13'h0000, fmt};
        {i[W_SPD_UP], i[W_SPD_LO]} = pair(r[0], 1'b0, 1'b0);
        i[W_STEPS] = 16'(r[1]);
        i[W_ENC] = 16'(r[2]);
        i[W_IDLE] = 16'(r[3]);
        i[W_CURR] = 16'(r[4]);
        return i;
    endfunction : cfg_img

    task automatic send_cmd(logic drv, logic [31:0] w);
        img = '0;
        img[W_CTRL_A] = {15'h0000, drv};
        {img[W_SPD_UP], img[W_SPD_LO]} = w;
        {img[4], img[5]} = w;
        {img[6], img[7]} = w;
        // word 5 carries speed here, so the reserved-word scrub is off
        i_host.send(img, 1'b1);
    endtask : send_cmd

    task automatic do_reset(logic nv);
        @(posedge clk_sys);
        rst <= 1'b1;
        nv_present <= nv;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : do_reset

    task automatic store(logic exp);
        @(posedge clk_sys);
        store_req <= 1'b1;
        @(posedge clk_sys);
        store_req <= 1'b0;
        #1 chk("nv_write", 32'(exp), 32'(nv_write));
    endtask : store

    initial begin
        rst = 1'b1;
        store_req = 1'b0;
        abs_encoder = 1'b0;
        nv_present = 1'b0;
        motor_pos = 32'd1234567;
        encoder_pos = 32'(-7654321);
        capture_pos = 32'h0000000c;
        nv_cfg = '0;
        nv_cfg.start_speed = 32'h000001f4;
        fmts = '{3'b000, 3'b011, 3'b111, 3'b001};
        tbl = '{'{1999999, 200, 1024, 100, 20, 0}, '{2000000, 400, 2048,
            50, 10, 1}, '{0, 400, 2048, 50, 10, 1}, '{1000, 199, 2048, 50,
            10, 1}, '{1, 32767, 4096, 0, 1, 0}, '{9, 32768, 2048, 50, 10, 1},
            '{9, 400, 3000, 50, 10, 1}, '{7, 400, 2048, 50, 10, 0}, '{9, 400,
            2048, 101, 10, 1}, '{9, 400, 2048, 50, 21, 1}, '{9, 400, 2048,
            50, 0, 1}};
        do_reset(1'b0);
        chk("cfg_valid", 0, 32'(cfg_valid));
        send_cmd(1'b1, 32'h0);
        chk("driver_enable", 0, 32'(driver_enable));
        store(1'b0);
        do_reset(1'b1);
        chk("start_speed", 32'h1f4, cfg_out.start_speed);
        send_cmd(1'b0, pair(-7654321, 1'b0, 1'b0));
        chk("driver_enable", 0, 32'(driver_enable));
        chk("target_pos", 32'(-7654321), target_pos);
        chk("prog_speed", 32'(-7654321), prog_speed);
        chk("stop_dist", 32'(-7654321), stop_dist);
        send_cmd(1'b1, pair(1234567, 1'b0, 1'b0));
        chk("driver_enable", 1, 32'(driver_enable));
        store(1'b1);
        last_spd = 500;
        foreach (tbl[k]) begin
            i_host.send(cfg_img(tbl[k], 3'b000), 1'b0);
            if (tbl[k][5] == 0) last_spd = tbl[k][0];
            chk("cfg_reject", 32'(tbl[k][5]), 32'(cfg_reject));
            chk("start_speed", 32'(last_spd), cfg_out.start_speed);
        end
        img = cfg_img(tbl[0], 3'b000);
        img[W_RSVD9] = 16'h0001;
        i_host.send(img, 1'b1);
        chk("cfg_reject", 1, 32'(cfg_reject));
        abs_encoder <= 1'b1;
        i_host.send(cfg_img(tbl[0], 3'b000), 1'b0);
        chk("cfg_reject", 1, 32'(cfg_reject));
        i_host.send(cfg_img(tbl[7], 3'b000), 1'b0);
        chk("cfg_reject", 0, 32'(cfg_reject));
        abs_encoder <= 1'b0;
        foreach (fmts[f]) begin
            i_host.send(cfg_img(tbl[0], fmts[f]), 1'b0);
            chk("config_mode", 1, 32'(config_mode));
            send_cmd(1'b1, pair(-7654321, fmts[f][0], fmts[f][2]));
            chk("config_mode", 0, 32'(config_mode));
            chk("target_pos", 32'(-7654321), target_pos);
            chk("prog_speed", 32'(-7654321), prog_speed);
            chk("stop_dist", 32'(-7654321), stop_dist);
            chk("capture_words", pair(12, fmts[f][1], fmts[f][2]),
                {in_image[6], in_image[7]});
            chk("motor_words", pair(1234567, fmts[f][1], fmts[f][2]),
                {in_image[2], in_image[3]});
            chk("encoder_words", pair(-7654321, fmts[f][1], fmts[f][2]),
                {in_image[4], in_image[5]});
            // status bits reach the returned image one cycle later
            @(posedge clk_sys);
            #1 chk("status_word", 32'h6000, 32'(in_image[0]));
            chk("spare_words", 0, {in_image[8], in_image[9]});
        end
        results();
    end

    initial begin
        repeat (2000) @(posedge clk_sys);
        n_fail++;
        results();
    end
endmodule : config_image_word_format_test

//--- verification/plc_host_model.sv
/* host side model: sends ten-word output images, one-cycle strobe.
   assumes the decoder takes out_image on clk_sys while image_valid. */
`timescale 1ns/100ps
module plc_host_model
    import cfg_image_pkg::*;
(
    input  wire logic             clk_sys,
    output cfg_image_pkg::image_t out_image,
    output logic                  image_valid
);
    initial begin
        out_image   = '0;
        image_valid = 1'b0;
    end

    // bad_rsvd lets a scenario leave the reserved words dirty
    task automatic send(input image_t img, input logic bad_rsvd);
        image_t w;
        w = img;
        if (!bad_rsvd) begin
            w[W_RSVD5] = '0;
            w[W_RSVD9] = '0;
        end
        @(posedge clk_sys);
        out_image   <= w;
        image_valid <= 1'b1;
        @(posedge clk_sys);
        // stale words are scrambled so nothing leans on them lingering
        out_image   <= ~w;
        image_valid <= 1'b0;
        #1;
    endtask : send
endmodule : plc_host_model

//--- verilog/cfg_image_decoder.sv
/*
 * decodes the host output image: selects configuration or command
 * operation, validates and holds the volatile configuration, commits it
 * to nonvolatile storage on request, and converts wide values between
 * the thousands-based two-word form and signed 32-bit words.
 * assumes image words and strobes come from logic on clk_sys; the
 * nonvolatile store sits outside and answers on nv_* ports.
 */
`timescale 1ns/100ps

module cfg_image_decoder
    import cfg_image_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire cfg_image_pkg::image_t   out_image,
    input  wire logic                    image_valid,
    input  wire logic                    store_req,
    input  wire logic                    abs_encoder,
    input  wire logic                    nv_present,
    input  wire cfg_image_pkg::cfg_t     nv_cfg,
    input  wire logic [31:0]             motor_pos,
    input  wire logic [31:0]             encoder_pos,
    input  wire logic [31:0]             capture_pos,
    output logic                         config_mode,
    output logic                         driver_enable,
    output logic                         cfg_valid,
    output logic                         cfg_reject,
    output logic                         nv_write,
    output cfg_image_pkg::cfg_t          cfg_out,
    output logic [31:0]                  target_pos,
    output logic [31:0]                  prog_speed,
    output logic [31:0]                  stop_dist,
    output cfg_image_pkg::image_t        in_image
);
    import cfg_image_pkg::*;

    // ****************************************************************
    // conversion helpers
    // ****************************************************************

    // two-word value: both words carry the sign, so a plain signed sum
    function automatic logic [31:0] mw_join(input logic [15:0] hi,
                                            input logic [15:0] lo);
        logic signed [31:0] h;
        logic signed [31:0] l;
        h = 32'(signed'(hi));
        l = 32'(signed'(lo));
        return 32'(h * MW_SCALE + l);
    endfunction : mw_join

    function automatic logic [31:0] wide_in(input logic [15:0] w0,
                                            input logic [15:0] w1,
                                            input logic        bin,
                                            input logic        be);
        if (!bin) begin
            return mw_join(w0, w1);
        end
        return be ? {w0, w1} : {w1, w0};
    endfunction : wide_in

    // out-of-span values are not clamped: the words are indeterminate
    // by contract, and clamping would hide wrap in continuous rotation
    function automatic logic [31:0] wide_out(input logic [31:0] v,
                                             input logic        bin,
                                             input logic        be);
        logic signed [31:0] s;
        logic signed [31:0] q;
        logic signed [31:0] r;
        s = signed'(v);
        q = s / MW_SCALE;
        r = s - q * MW_SCALE;
        if (!bin) begin
            return {q[15:0], r[15:0]};
        end
        return be ? v : {v[15:0], v[31:16]};
    endfunction : wide_out

    // ****************************************************************
    // validation of the configuration image
    // ****************************************************************

    logic [31:0] spd_nxt;
    logic        spd_ok;
    logic        steps_ok;
    logic        enc_ok;
    logic        idle_ok;
    logic        curr_ok;
    logic        rsvd_ok;
    logic        image_ok;
    logic        use_enc;
    logic [15:0] enc_w;

    assign spd_nxt  = mw_join(out_image[W_SPD_UP], out_image[W_SPD_LO]);
    assign spd_ok   = signed'(spd_nxt) >= SPD_MIN
                   && signed'(spd_nxt) <= SPD_MAX;
    assign steps_ok = out_image[W_STEPS] >= 16'(STEPS_MIN)
                   && out_image[W_STEPS] <= 16'(STEPS_MAX);
    assign use_enc  = out_image[W_CTRL_A][10];
    assign enc_w    = out_image[W_ENC];
    assign enc_ok   = !use_enc
                   || (abs_encoder ? enc_w == 16'(ENC_2K)
                       : (enc_w == 16'(ENC_1K) || enc_w == 16'(ENC_2K)
                          || enc_w == 16'(ENC_4K)));
    assign idle_ok  = out_image[W_IDLE] <= 16'(IDLE_MAX);
    assign curr_ok  = out_image[W_CURR] >= 16'(CURR_MIN)
                   && out_image[W_CURR] <= 16'(CURR_MAX);
    assign rsvd_ok  = out_image[W_RSVD5] == RST_WORD
                   && out_image[W_RSVD9] == RST_WORD;
    assign image_ok = spd_ok && steps_ok && enc_ok && idle_ok
                   && curr_ok && rsvd_ok;

    // ****************************************************************
    // operation state
    // ****************************************************************

    op_state_t state_r;
    logic      cfg_sel;

    assign cfg_sel = out_image[W_CTRL_A][B_MODE_SEL];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= ST_BOOT;
        end else begin
            unique case (state_r)
                ST_BOOT: begin
                    state_r <= ST_COMMAND;
                end
                ST_COMMAND: begin
                    if (image_valid && cfg_sel) begin
                        state_r <= ST_CONFIG;
                    end
                end
                ST_CONFIG: begin
                    if (image_valid && !cfg_sel) begin
                        state_r <= ST_COMMAND;
                    end
                end
                default: begin
                    state_r <= ST_BOOT;
                end
            endcase
        end
    end

    // a taken image moves the flag at the same edge as the state, so the
    // mode answer never lags a command image by a cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            config_mode <= 1'b0;
        end else if (state_r != ST_BOOT && image_valid) begin
            config_mode <= cfg_sel;
        end else begin
            config_mode <= state_r == ST_CONFIG;
        end
    end

    // ****************************************************************
    // volatile configuration and store
    // ****************************************************************

    // the held copy is RAM-like: it is lost with power and only reaches
    // nonvolatile storage through the store request
    logic boot_load;
    logic cfg_take;

    assign boot_load = state_r == ST_BOOT && nv_present;
    assign cfg_take  = image_valid && cfg_sel && state_r != ST_BOOT;

    // refusal reflects only the latest configuration image
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_reject <= 1'b0;
        end else if (cfg_take) begin
            cfg_reject <= !image_ok;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_valid <= 1'b0;
        end else if (boot_load || (cfg_take && image_ok)) begin
            cfg_valid <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_out <= '0;
        end else if (boot_load) begin
            cfg_out <= nv_cfg;
        end else if (cfg_take && image_ok) begin
            cfg_out.ctrl_a         <= out_image[W_CTRL_A];
            cfg_out.ctrl_b         <= out_image[W_CTRL_B];
            cfg_out.use_bin_out    <= out_image[W_CTRL_B][B_OUT_FMT];
            cfg_out.use_bin_in     <= out_image[W_CTRL_B][B_IN_FMT];
            cfg_out.big_endian     <= out_image[W_CTRL_B][B_ENDIAN];
            cfg_out.start_speed    <= spd_nxt;
            cfg_out.steps_per_rev  <= out_image[W_STEPS];
            cfg_out.encoder_counts <= out_image[W_ENC];
            cfg_out.idle_pct       <= out_image[W_IDLE];
            cfg_out.run_current    <= out_image[W_CURR];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            nv_write <= 1'b0;
        end else begin
            nv_write <= store_req && cfg_valid && state_r != ST_BOOT;
        end
    end

    // ****************************************************************
    // command data and driver enable
    // ****************************************************************

    logic cmd_take;
    assign cmd_take = image_valid && !cfg_sel && state_r != ST_BOOT;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            driver_enable <= 1'b0;
        end else if (cmd_take) begin
            driver_enable <= out_image[W_CTRL_A][B_DRV_EN]
                          && cfg_valid;
        end
    end

    // host-written wide parameters use the output-format bit; entry k
    // sits in command words 2k+2 and 2k+3 (target, speed, stop distance)
    logic [31:0] cmd_wide_r [3];

    for (genvar k = 0; k < 3; k++) begin : g_cmd_wide
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                cmd_wide_r[k] <= '0;
            end else if (cmd_take) begin
                cmd_wide_r[k] <= wide_in(out_image[2*k+2],
                                         out_image[2*k+3],
                                         cfg_out.use_bin_out,
                                         cfg_out.big_endian);
            end
        end
    end

    assign target_pos = cmd_wide_r[0];
    assign prog_speed = cmd_wide_r[1];
    assign stop_dist  = cmd_wide_r[2];

    // ****************************************************************
    // returned image
    // ****************************************************************

    logic [31:0] pos_in [3];
    logic [31:0] pos_w  [3];

    assign pos_in[0] = motor_pos;
    assign pos_in[1] = encoder_pos;
    assign pos_in[2] = capture_pos;

    // one converter per returned position: motor, encoder, capture
    for (genvar k = 0; k < 3; k++) begin : g_ret_wide
        assign pos_w[k] = wide_out(pos_in[k], cfg_out.use_bin_in,
                                   cfg_out.big_endian);
    end

    // entry k returns in words 2k+2 (first) and 2k+3 (second)
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in_image <= '0;
        end else begin
            in_image    <= '0;
            in_image[0] <= {config_mode, driver_enable, cfg_valid,
                            cfg_reject, 12'h000};
            for (int k = 0; k < 3; k++) begin
                in_image[2*k+2] <= pos_w[k][31:16];
                in_image[2*k+3] <= pos_w[k][15:0];
            end
        end
    end

endmodule : cfg_image_decoder
